/* rtl/cis_pkg.sv */
// Functional notes
// - during a forms operation a low paper-exhausted input sets end-of-paper status
// - ready button pressed when open contact reads low and closed contact high
// - each keyboard character line is active low; low gives a one
// - mechanical sampling is paced by the shaft timing pulse
// - right tacho watched only while right select high; left likewise
// - photocell position pulses are counted to track the carrier
// - each counted position pulse decrements the stored carrier position by one
// - a delay suppresses the position count signal for 12.5 ms
// - single-position move masks count-is-one for 10 ms and sets single-step flag
// - operate-carrier asserted only when the received carrier word is nonzero
// - carrier-word indication raised when a carrier word arrives on info lines
// - carrier buffer flags remaining count equal to one
// - carrier buffer flags remaining count less than or equal to six
// - end-of-paper reported in status word bit 2
// - keyboard-ready status bit 12 is one while key data interrupt is set
// - status bit 14 set when a key arrives before the previous one left
package cis_pkg;

  // ==========================================================================
  // register bus
  // ==========================================================================
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 16;
  localparam logic [3:0]  REG_STATUS     = 4'h0;
  localparam logic [3:0]  REG_KEY_DATA   = 4'h1;
  localparam logic [3:0]  REG_CONTROL    = 4'h2;
  localparam logic [3:0]  REG_CARRIER    = 4'h3;
  localparam logic [3:0]  REG_CARR_STAT  = 4'h4;
  localparam logic [3:0]  REG_IRQ_STAT   = 4'h5;
  localparam logic [3:0]  REG_IRQ_CLEAR  = 4'h6;
  localparam logic [3:0]  REG_IRQ_ENABLE = 4'h7;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int STAT_EOP_BIT     = 1;   // status word bit 2
  localparam int STAT_KEY_RDY_BIT = 11;  // status word bit 12
  localparam int STAT_READY_BIT   = 12;  // status word bit 13
  localparam int STAT_MISSED_BIT  = 13;  // status word bit 14
  localparam int CTL_FORMS_BIT    = 0;
  localparam int CTL_KBD_EN_BIT   = 1;
  localparam int CTL_CLR_MISS_BIT = 2;
  localparam int IRQ_W            = 5;
  localparam int EV_KEY           = 0;
  localparam int EV_MISSED        = 1;
  localparam int EV_EOP           = 2;
  localparam int EV_READY         = 3;
  localparam int EV_CARR_DONE     = 4;
  localparam int CARR_W           = 8;

  // ==========================================================================
  // reset values and synchroniser layout
  // ==========================================================================
  localparam logic        RST_KBD_EN     = 1'b1;
  localparam logic [4:0]  RST_IRQ_EN     = 5'h00;
  localparam int          SYNC_W         = 18;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 100;
  localparam int INHIBIT_TIME_US = 12500;  // 12.5 ms
  localparam int MASK_TIME_MS    = 10;
  localparam int INHIBIT_CYCLES  = INHIBIT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int MASK_CYCLES     = MASK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DELAY_CNT_W     = 17;

endpackage

/* rtl/cis_sync.sv */
`timescale 1ns/1ps
module cis_sync #(
  parameter int WIDTH = cis_pkg::SYNC_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import cis_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cis_sync_s;

  cis_sync_s s_q;
  cis_sync_s s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule

/* rtl/cis_delay.sv */
`timescale 1ns/1ps
module cis_delay #(
  parameter int CYCLES = 100
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // control
  input  wire logic start,
  output logic      busy
);
  import cis_pkg::*;

  typedef struct packed {
    logic                   busy;
    logic [DELAY_CNT_W-1:0] cnt;
  } cis_delay_s;

  cis_delay_s s_q;
  cis_delay_s s_d;

  // busy stands exactly CYCLES cycles; a new start restarts the window
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = DELAY_CNT_W'(CYCLES - 1);
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;

endmodule

/* rtl/cis_top.sv */
`timescale 1ns/1ps
module cis_top #(
  parameter int INHIBIT_CYC = cis_pkg::INHIBIT_CYCLES,
  parameter int MASK_CYC    = cis_pkg::MASK_CYCLES
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  // register port
  input  wire logic [cis_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [cis_pkg::DATA_W-1:0]  memory_info_lines,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [cis_pkg::DATA_W-1:0]  external_bus_bits,
  output logic                             irq,
  // keyboard
  input  wire logic [7:0]                  key_char_bits_n,
  input  wire logic                        key_char_strobe,
  output logic                             key_data_interrupt,
  output logic                             key_interrupt_missed_n,
  // switches and paper
  input  wire logic                        paper_exhausted_n,
  input  wire logic                        ready_switch_open_contact,
  input  wire logic                        ready_switch_closed_contact_n,
  input  wire logic                        shaft_timing_pulse,
  // tachometer
  input  wire logic                        tacho_right_select,
  input  wire logic                        tacho_left_select,
  input  wire logic                        tacho_right_out,
  input  wire logic                        tacho_left_out,
  output logic                             tacho_feedback,
  // carrier
  input  wire logic                        carrier_photocell_pulse_n,
  output logic                             carrier_word_present,
  output logic                             operate_carrier,
  output logic                             carrier_position_decrement_n,
  output logic                             count_inhibit_delay_n,
  output logic                             carrier_count_is_one,
  output logic                             carrier_count_le_six,
  output logic                             single_step_flag
);
  import cis_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic              strb_prev;
    logic              shaft_prev;
    logic              photo_prev_n;
    logic [7:0]        key_buf;
    logic              key_int;
    logic              key_missed_n;
    logic              kbd_en;
    logic              forms_act;
    logic              eop;
    logic              ready;
    logic              tacho_fb;
    logic [CARR_W-1:0] carr_cnt;
    logic              carr_word;
    logic              op_carr;
    logic              dec_n;
    logic              single_step;
    logic              inh_start;
    logic              mask_start;
    logic              inh_n;
    logic              eq1;
    logic              le6;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_en;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } cis_state_s;

  cis_state_s s_q;
  cis_state_s s_d;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // register select, used by the write strobes and the key-data read
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    reg_hit = (a == idx);
  endfunction

  function automatic logic cnt_is_one(input logic [CARR_W-1:0] c);
    cnt_is_one = (c == CARR_W'(1));
  endfunction

  function automatic logic cnt_le_six(input logic [CARR_W-1:0] c);
    cnt_le_six = (c <= CARR_W'(6));
  endfunction

  // ==========================================================================
  // synchronisers and delays
  // ==========================================================================
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic [7:0]        key_bits_s;
  logic              key_strobe_s;
  logic              paper_n_s;
  logic              ready_open_s;
  logic              ready_closed_n_s;
  logic              shaft_s;
  logic              tr_sel_s;
  logic              tl_sel_s;
  logic              tr_out_s;
  logic              tl_out_s;
  logic              photo_n_s;
  logic              inh_busy;
  logic              mask_busy;

  // every console input is brought into the clock domain first
  assign raw_in = {key_char_bits_n, key_char_strobe, paper_exhausted_n,
                   ready_switch_open_contact, ready_switch_closed_contact_n,
                   shaft_timing_pulse, tacho_right_select, tacho_left_select,
                   tacho_right_out, tacho_left_out, carrier_photocell_pulse_n};

  cis_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign {key_bits_s, key_strobe_s, paper_n_s, ready_open_s, ready_closed_n_s,
          shaft_s, tr_sel_s, tl_sel_s, tr_out_s, tl_out_s, photo_n_s} = sync_in;

  // count inhibit window after a carrier word
  cis_delay #(
    .CYCLES (INHIBIT_CYC)
  ) u_inhibit (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (s_q.inh_start),
    .busy     (inh_busy)
  );

  // one-position mask window
  cis_delay #(
    .CYCLES (MASK_CYC)
  ) u_mask (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (s_q.mask_start),
    .busy     (mask_busy)
  );

  // ==========================================================================
  // access decode and edges
  // ==========================================================================
  logic             wr_control;
  logic             wr_carrier;
  logic             wr_irq_clr;
  logic             wr_irq_en;
  logic             rd_key;
  logic             key_edge;
  logic             shaft_tick;
  logic             photo_edge;
  logic [IRQ_W-1:0] events;
  logic [CARR_W-1:0] carr_word_in;

  assign wr_control   = reg_write & reg_hit(reg_addr, REG_CONTROL);
  assign wr_carrier   = reg_write & reg_hit(reg_addr, REG_CARRIER);
  assign wr_irq_clr   = reg_write & reg_hit(reg_addr, REG_IRQ_CLEAR);
  assign wr_irq_en    = reg_write & reg_hit(reg_addr, REG_IRQ_ENABLE);
  assign rd_key       = reg_read & reg_hit(reg_addr, REG_KEY_DATA);
  assign carr_word_in = memory_info_lines[CARR_W-1:0];

  // edges look only at second-stage outputs and their own history
  assign key_edge   = key_strobe_s & ~s_q.strb_prev;
  assign shaft_tick = shaft_s & ~s_q.shaft_prev;
  assign photo_edge = ~photo_n_s & s_q.photo_prev_n;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    s_d              = s_q;
    events           = '0;
    s_d.strb_prev    = key_strobe_s;
    s_d.shaft_prev   = shaft_s;
    s_d.photo_prev_n = photo_n_s;

    // control register
    if (wr_control) begin
      s_d.forms_act = memory_info_lines[CTL_FORMS_BIT];
      s_d.kbd_en    = memory_info_lines[CTL_KBD_EN_BIT];
      if (memory_info_lines[CTL_CLR_MISS_BIT]) begin
        s_d.key_missed_n = 1'b1;
      end
    end

    // keyboard: reading the data register clears the key interrupt
    if (rd_key) begin
      s_d.key_int = 1'b0;
    end
    if (key_edge && s_q.kbd_en) begin
      if (s_q.key_int && !rd_key) begin
        s_d.key_missed_n = 1'b0;
        events[EV_MISSED] = 1'b1;
      end else begin
        s_d.key_buf = ~key_bits_s;
        s_d.key_int = 1'b1;
        events[EV_KEY] = 1'b1;
      end
    end

    // end of paper is only meaningful while forms run
    if (!s_q.forms_act) begin
      s_d.eop = 1'b0;
    end else if (!paper_n_s) begin
      s_d.eop = 1'b1;
      events[EV_EOP] = ~s_q.eop;
    end

    // switch and tacho sampled on the shaft timing tick, which also filters bounce
    if (shaft_tick) begin
      s_d.ready    = ~ready_open_s & ready_closed_n_s;
      events[EV_READY] = s_d.ready & ~s_q.ready;
      s_d.tacho_fb = (tr_sel_s & tr_out_s) | (tl_sel_s & tl_out_s);
    end

    // carrier word load and position counting
    s_d.carr_word  = 1'b0;
    s_d.inh_start  = 1'b0;
    s_d.mask_start = 1'b0;
    s_d.dec_n      = 1'b1;
    if (wr_carrier) begin
      s_d.carr_cnt    = carr_word_in;
      s_d.carr_word   = 1'b1;
      s_d.op_carr     = (carr_word_in != '0);
      s_d.inh_start   = 1'b1;
      s_d.single_step = cnt_is_one(carr_word_in);
      s_d.mask_start  = cnt_is_one(carr_word_in);
    end else if (photo_edge && !inh_busy && s_q.carr_cnt != '0) begin
      // pulses in the inhibit window are dropped, not deferred
      s_d.carr_cnt = s_q.carr_cnt - 1'b1;
      s_d.dec_n    = 1'b0;
      if (s_q.carr_cnt == CARR_W'(1)) begin
        s_d.op_carr = 1'b0;
        events[EV_CARR_DONE] = 1'b1;
      end
    end
    s_d.inh_n = ~inh_busy;
    s_d.eq1   = cnt_is_one(s_d.carr_cnt) & ~mask_busy & ~s_d.mask_start & ~s_q.mask_start;
    s_d.le6   = cnt_le_six(s_d.carr_cnt);

    // interrupts: clear first so a same-cycle event survives
    if (wr_irq_clr) begin
      s_d.irq_stat = s_q.irq_stat & ~memory_info_lines[IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | events;
    if (wr_irq_en) begin
      s_d.irq_en = memory_info_lines[IRQ_W-1:0];
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);

    // read data stands one cycle only
    s_d.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        REG_STATUS: begin
          s_d.rdata[STAT_EOP_BIT]     = s_q.eop;
          s_d.rdata[STAT_KEY_RDY_BIT] = s_q.key_int;
          s_d.rdata[STAT_READY_BIT]   = s_q.ready;
          s_d.rdata[STAT_MISSED_BIT]  = ~s_q.key_missed_n;
        end
        REG_KEY_DATA: begin
          s_d.rdata[7:0] = s_q.key_buf;
        end
        REG_CONTROL: begin
          s_d.rdata[CTL_FORMS_BIT]  = s_q.forms_act;
          s_d.rdata[CTL_KBD_EN_BIT] = s_q.kbd_en;
        end
        REG_CARRIER: begin
          s_d.rdata[CARR_W-1:0] = s_q.carr_cnt;
        end
        REG_CARR_STAT: begin
          s_d.rdata[5:0] = {s_q.tacho_fb, s_q.single_step, s_q.le6,
                            s_q.eq1, ~s_q.inh_n, s_q.op_carr};
        end
        REG_IRQ_STAT: begin
          s_d.rdata[IRQ_W-1:0] = s_q.irq_stat;
        end
        REG_IRQ_ENABLE: begin
          s_d.rdata[IRQ_W-1:0] = s_q.irq_en;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q              <= '0;
      s_q.key_missed_n <= 1'b1;
      s_q.kbd_en       <= RST_KBD_EN;
      s_q.dec_n        <= 1'b1;
      s_q.inh_n        <= 1'b1;
      // photo history resets low like the synchroniser, so no false edge
      s_q.le6          <= 1'b1;
      s_q.irq_en       <= RST_IRQ_EN;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  // ==========================================================================
  assign external_bus_bits            = s_q.rdata;
  assign irq                          = s_q.irq;
  assign key_data_interrupt           = s_q.key_int;
  assign key_interrupt_missed_n       = s_q.key_missed_n;
  assign tacho_feedback               = s_q.tacho_fb;
  assign carrier_word_present         = s_q.carr_word;
  assign operate_carrier              = s_q.op_carr;
  assign carrier_position_decrement_n = s_q.dec_n;
  assign count_inhibit_delay_n        = s_q.inh_n;
  assign carrier_count_is_one         = s_q.eq1;
  assign carrier_count_le_six         = s_q.le6;
  assign single_step_flag             = s_q.single_step;

endmodule

/* dv/cis_top_props.sv */
`timescale 1ns/1ps
// ==========================================================================
// port watchers
module cis_top_props import cis_pkg::*; #(
  parameter int INHIBIT_CYC = 20,
  parameter int MASK_CYC    = 10
) (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       reset,
  // register port
  input wire logic [cis_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cis_pkg::DATA_W-1:0] memory_info_lines,
  input wire logic                       reg_write,
  input wire logic                       reg_read,
  input wire logic [cis_pkg::DATA_W-1:0] external_bus_bits,
  // keyboard
  input wire logic                       key_char_strobe,
  input wire logic                       key_data_interrupt,
  input wire logic                       key_interrupt_missed_n,
  // carrier
  input wire logic                       carrier_word_present,
  input wire logic                       operate_carrier,
  input wire logic                       carrier_position_decrement_n,
  input wire logic                       count_inhibit_delay_n,
  input wire logic                       carrier_count_is_one,
  input wire logic                       carrier_count_le_six,
  input wire logic                       single_step_flag
);
  localparam int INH_LO = INHIBIT_CYC - 1;
  localparam int INH_HI = INHIBIT_CYC + 1;
  logic wr_carr, nz, one;
  // carrier word decode
  assign wr_carr = reg_write && reg_addr == REG_CARRIER;
  assign nz      = memory_info_lines[7:0] != 8'h00;
  assign one     = memory_info_lines[7:0] == 8'h01;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // carrier
  property p_word_present; wr_carr |=> carrier_word_present; endproperty
  a_word_present: assert property (p_word_present) else $error("no word pulse");
  property p_operate; wr_carr |=> operate_carrier == $past(nz); endproperty
  a_operate: assert property (p_operate) else $error("operate wrong");
  property p_le_six; wr_carr && memory_info_lines[7:0] <= 8'h06 |-> ##[1:2] carrier_count_le_six; endproperty
  a_le_six: assert property (p_le_six) else $error("le six missing");
  property p_mask; wr_carr && one |-> ##1 !carrier_count_is_one [*6]; endproperty
  a_mask: assert property (p_mask) else $error("eq1 not masked");
  property p_single; wr_carr |=> single_step_flag == $past(one); endproperty
  a_single: assert property (p_single) else $error("single step wrong");
  property p_inhibit;
    wr_carr && nz |-> ##3 !count_inhibit_delay_n ##[INH_LO:INH_HI] count_inhibit_delay_n;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit length");
  property p_no_count;
    !count_inhibit_delay_n && !$past(count_inhibit_delay_n) && !$past(count_inhibit_delay_n, 2)
      |-> carrier_position_decrement_n;
  endproperty
  a_no_count: assert property (p_no_count) else $error("count in inhibit");
  // ==========================================================================
  // keyboard
  property p_key_rdy;
    reg_read && reg_addr == REG_STATUS |=> external_bus_bits[STAT_KEY_RDY_BIT] == $past(key_data_interrupt);
  endproperty
  a_key_rdy: assert property (p_key_rdy) else $error("key ready wrong");
  property p_missed;
    reg_read && reg_addr == REG_STATUS |=> external_bus_bits[STAT_MISSED_BIT] == !$past(key_interrupt_missed_n);
  endproperty
  a_missed: assert property (p_missed) else $error("missed wrong");
  property p_capture; $rose(key_char_strobe) && !key_data_interrupt |-> ##[3:5] key_data_interrupt; endproperty
  a_capture: assert property (p_capture) else $error("key not captured");
endmodule

/* dv/cis_console_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// console mechanism model
module cis_console_model (
  // clock
  input  wire logic core_clk,
  // console lines
  output logic [7:0] key_char_bits_n,
  output logic       key_char_strobe,
  output logic       paper_exhausted_n,
  output logic       ready_switch_open_contact,
  output logic       ready_switch_closed_contact_n,
  output logic       shaft_timing_pulse,
  output logic       tacho_right_select,
  output logic       tacho_left_select,
  output logic       tacho_right_out,
  output logic       tacho_left_out,
  output logic       carrier_photocell_pulse_n
);
  logic       shaft_run = 1'b1;
  logic [2:0] shaft_cnt = 3'h0;
  // idle: paper in, button released
  initial begin
    {key_char_bits_n, key_char_strobe, carrier_photocell_pulse_n, shaft_timing_pulse} = 11'h7FA;
    {paper_exhausted_n, ready_switch_open_contact, ready_switch_closed_contact_n, tacho_right_select,
     tacho_left_select, tacho_right_out, tacho_left_out} = 7'h60;
  end
  // shaft tick every eight cycles; can be stopped to show pacing
  always @(posedge core_clk) begin
    shaft_cnt <= shaft_cnt + 3'h1;
    shaft_timing_pulse <= shaft_run && shaft_cnt == 3'h0;
  end
  task automatic press_key(input logic [7:0] c);
    @(posedge core_clk);
    key_char_bits_n <= ~c; // low line is a one
    @(posedge core_clk);
    key_char_strobe <= 1'b1; // lines settled first
    repeat (4) @(posedge core_clk);
    key_char_strobe <= 1'b0;
    @(posedge core_clk);
    key_char_bits_n <= c; // lines no longer valid: show the inverse
  endtask
  task automatic photo_pulse();
    @(posedge core_clk);
    carrier_photocell_pulse_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    carrier_photocell_pulse_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic set_lines(input logic [6:0] v);
    @(posedge core_clk);
    {paper_exhausted_n, ready_switch_open_contact, ready_switch_closed_contact_n, tacho_right_select,
     tacho_left_select, tacho_right_out, tacho_left_out} <= v;
  endtask
endmodule

/* dv/cis_top_test.sv */
`timescale 1ns/1ps
// ==========================================================================
// register-level tests
module cis_top_test;
  import cis_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr;
  logic [15:0] memory_info_lines, external_bus_bits;
  logic irq, reg_write, reg_read, key_char_strobe, paper_exhausted_n, rdy_o, rdy_c_n, shaft, rsel, lsel, rout, lout;
  logic photo_n, tfb;
  logic [7:0] key_char_bits_n;
  int n_fail = 0, checked = 0, cyc = 0;
  logic [7:0] keys [3] = '{8'h01, 8'h80, 8'hA5};
  logic [6:0] ln [7] = '{7'h40, 7'h70, 7'h6A, 7'h69, 7'h65, 7'h66, 7'h20};
  logic [15:0] ex [7] = '{16'h0000, 16'h0000, 16'h0028, 16'h0008, 16'h0028, 16'h0008, 16'h0000};
  always #50 core_clk = ~core_clk;
  cis_top #(.INHIBIT_CYC(20), .MASK_CYC(10)) dut (.core_clk, .reset, .reg_addr, .memory_info_lines, .reg_write,
    .reg_read, .external_bus_bits, .irq, .key_char_bits_n, .key_char_strobe, .key_data_interrupt(),
    .key_interrupt_missed_n(), .paper_exhausted_n, .ready_switch_open_contact(rdy_o),
    .ready_switch_closed_contact_n(rdy_c_n), .shaft_timing_pulse(shaft), .tacho_right_select(rsel),
    .tacho_left_select(lsel), .tacho_right_out(rout), .tacho_left_out(lout), .tacho_feedback(tfb),
    .carrier_photocell_pulse_n(photo_n), .carrier_word_present(), .operate_carrier(),
    .carrier_position_decrement_n(), .count_inhibit_delay_n(), .carrier_count_is_one(), .carrier_count_le_six(),
    .single_step_flag());
  cis_console_model con (.core_clk, .key_char_bits_n, .key_char_strobe, .paper_exhausted_n,
    .ready_switch_open_contact(rdy_o), .ready_switch_closed_contact_n(rdy_c_n), .shaft_timing_pulse(shaft),
    .tacho_right_select(rsel), .tacho_left_select(lsel), .tacho_right_out(rout), .tacho_left_out(lout),
    .carrier_photocell_pulse_n(photo_n));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {reg_addr, memory_info_lines, reg_write} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  // data stands one cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check($sformatf("reg %h", a), external_bus_bits, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {reg_addr, memory_info_lines, reg_write, reg_read} = '0;
    idle(16);
    reset <= 1'b0;
    rc(REG_STATUS, 16'h0000);
    rc(REG_CONTROL, 16'h0002);
    rc(REG_CARR_STAT, 16'h0008);
    rc(4'hF, 16'h0000);
    wr(REG_IRQ_ENABLE, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      con.press_key(keys[i]);
      idle(8);
      rc(REG_STATUS, 16'h0800);
      check("irq", 16'(irq), 16'h0001);
      rc(REG_KEY_DATA, {8'h00, keys[i]});
      rc(REG_STATUS, 16'h0000);
      wr(REG_IRQ_CLEAR, 16'h0001);
      idle(2);
      check("irq", 16'(irq), 16'h0000);
    end
    con.press_key(8'h11);
    idle(8);
    con.press_key(8'h22);
    idle(8);
    rc(REG_STATUS, 16'h2800);
    rc(REG_IRQ_STAT, 16'h0003);
    rc(REG_KEY_DATA, 16'h0011);
    wr(REG_CONTROL, 16'h0006);
    rc(REG_STATUS, 16'h0000);
    wr(REG_IRQ_ENABLE, 16'h0000);
    idle(2);
    check("irq masked", 16'(irq), 16'h0000);
    wr(REG_IRQ_CLEAR, 16'h001F);
    rc(REG_IRQ_STAT, 16'h0000);
    con.shaft_run <= 1'b0;
    con.set_lines(7'h50);
    idle(30);
    rc(REG_STATUS, 16'h0000);
    con.shaft_run <= 1'b1;
    idle(30);
    rc(REG_STATUS, 16'h1000);
    for (int i = 0; i < 7; i++) begin
      con.set_lines(ln[i]);
      idle(30);
      rc((i inside {[2:5]}) ? REG_CARR_STAT : REG_STATUS, ex[i]);
      check("tacho", 16'(tfb), 16'(ex[i][5]));
    end
    wr(REG_CONTROL, 16'h0003);
    idle(8);
    rc(REG_STATUS, 16'h0002);
    rc(REG_IRQ_STAT, 16'h000C);
    wr(REG_CONTROL, 16'h0002);
    con.set_lines(7'h60);
    wr(REG_CARRIER, 16'h0005);
    con.photo_pulse();
    rc(REG_CARRIER, 16'h0005);
    idle(30);
    con.photo_pulse();
    con.photo_pulse();
    rc(REG_CARRIER, 16'h0003);
    rc(REG_CARR_STAT, 16'h0009);
    wr(REG_CARRIER, 16'h0002);
    idle(30);
    con.photo_pulse();
    rc(REG_CARR_STAT, 16'h000D);
    wr(REG_CARRIER, 16'h0001);
    idle(30);
    rc(REG_CARR_STAT, 16'h001D);
    con.photo_pulse();
    rc(REG_CARR_STAT, 16'h0018);
    rc(REG_IRQ_STAT, 16'h001C);
    wr(REG_CARRIER, 16'h0000);
    idle(30);
    con.photo_pulse();
    rc(REG_CARR_STAT, 16'h0008);
    rc(REG_CARRIER, 16'h0000);
    finish_test();
  end
endmodule
bind cis_top cis_top_props #(.INHIBIT_CYC(INHIBIT_CYC), .MASK_CYC(MASK_CYC)) props (.core_clk, .reset, .reg_addr,
  .memory_info_lines, .reg_write, .reg_read, .external_bus_bits, .key_char_strobe, .key_data_interrupt,
  .key_interrupt_missed_n, .carrier_word_present, .operate_carrier, .carrier_position_decrement_n,
  .count_inhibit_delay_n, .carrier_count_is_one, .carrier_count_le_six, .single_step_flag);
